//--- acr_pkg.sv
// Package: register map, field layout, reset values and decoded setting types
package acr_pkg;

  // Printed offsets are not byte addresses: they are register indices, shifted left two bits below
  localparam logic [7:0] IDX_ANALOG_GAIN = 8'h42;
  localparam logic [7:0] IDX_VOLUME = 8'h43;
  localparam logic [7:0] IDX_GAIN_TRIM = 8'h44;
  localparam logic [7:0] IDX_PHASE_TRIM = 8'h45;
  localparam logic [7:0] IDX_INPUT_SETUP = 8'h46;
  localparam int unsigned ADDR_W = 12;
  localparam logic [ADDR_W-1:0] ADDR_ANALOG_GAIN = {2'h0, IDX_ANALOG_GAIN, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_VOLUME = {2'h0, IDX_VOLUME, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_GAIN_TRIM = {2'h0, IDX_GAIN_TRIM, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_PHASE_TRIM = {2'h0, IDX_PHASE_TRIM, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_INPUT_SETUP = {2'h0, IDX_INPUT_SETUP, 2'h0};

  // Reset values
  localparam logic [7:0] RST_ANALOG_GAIN = 8'h00;
  localparam logic [7:0] RST_VOLUME = 8'hc9;
  localparam logic [7:0] RST_GAIN_TRIM = 8'h80;
  localparam logic [7:0] RST_PHASE_TRIM = 8'h00;
  localparam logic [7:0] RST_INPUT_SETUP = 8'h00;

  // Writable-bit masks; reserved bits are zero here
  localparam logic [7:0] MASK_ANALOG_GAIN = 8'hfc;
  localparam logic [7:0] MASK_VOLUME = 8'hff;
  localparam logic [7:0] MASK_GAIN_TRIM = 8'hf0;
  localparam logic [7:0] MASK_PHASE_TRIM = 8'hff;
  localparam logic [7:0] MASK_INPUT_SETUP = 8'hfd;

  // Field positions
  localparam int unsigned GAIN_LSB = 2;
  localparam int unsigned TRIM_LSB = 4;
  localparam int unsigned LINE_BIT = 7;
  localparam int unsigned SRC_LSB = 5;
  localparam int unsigned DC_BIT = 4;
  localparam int unsigned IMP_LSB = 2;
  localparam int unsigned ENH_BIT = 0;

  // Code points
  localparam logic [5:0] GAIN_MAX_CODE = 6'h2a;
  localparam logic [7:0] VOLUME_MUTE_CODE = 8'h00;
  localparam logic [7:0] VOLUME_UNITY_CODE = 8'hc9;
  localparam logic [3:0] TRIM_ZERO_CODE = 4'h8;

  typedef enum logic [1:0] {
    SRC_ANALOG_DIFF,
    SRC_ANALOG_SINGLE,
    SRC_DIGITAL_PDM,
    SRC_RESERVED
  } acr_source_e;

  // Channel-two settings as seen by the signal path
  typedef struct packed {
    logic [5:0] gain_db;
    logic gain_reserved;
    logic mute;
    logic signed [9:0] volume_half_db;
    logic signed [3:0] trim_tenth_db;
    logic [7:0] phase_delay_cycles;
    logic phase_delay_on;
  } acr_chan_b_s;

  // Channel-three input setup as seen by the front end
  typedef struct packed {
    logic line_select;
    acr_source_e source_select;
    logic dc_coupling;
    logic [1:0] impedance_select;
    logic impedance_reserved;
    logic enhancer_enable;
    logic dynamic_range_enhancer;
    logic automatic_gain_control;
  } acr_chan_c_s;

endpackage : acr_pkg

//--- acr_regs.sv
// Channel configuration register bank with APB slave and decoded outputs
//
// The APB register port was decided locally.
`timescale 1ns/10ps

module acr_regs
  import acr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic automatic_gain_control_select,
  output acr_chan_b_s chan_b,
  output acr_chan_c_s chan_c
);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [7:0] chan_b_analog_gain;
  logic [7:0] chan_b_digital_volume;
  logic [7:0] chan_b_gain_trim;
  logic [7:0] chan_b_phase_trim;
  logic [7:0] chan_c_input_setup;
  logic access;
  logic wr_en;
  logic hit;
  logic [7:0] rd_val;

  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    addr_mapped = (a == ADDR_ANALOG_GAIN) || (a == ADDR_VOLUME) ||
                  (a == ADDR_GAIN_TRIM) || (a == ADDR_PHASE_TRIM) ||
                  (a == ADDR_INPUT_SETUP);
  endfunction : addr_mapped

  // Masking on write keeps reserved bits at zero forever
  function automatic logic [7:0] merge(input logic [7:0] old,
                                       input logic [7:0] mask);
    merge = pstrb[0] ? (pwdata[7:0] & mask) : old;
  endfunction : merge

  // Zero-wait slave: every access finishes in its first access cycle
  assign pready = 1'b1;
  assign access = psel && penable;
  assign hit = addr_mapped(paddr);
  assign wr_en = access && pwrite && hit;

  // ----------------------------------------------------------------
  // Writes
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_b_analog_gain <= RST_ANALOG_GAIN;
      chan_b_digital_volume <= RST_VOLUME;
      chan_b_gain_trim <= RST_GAIN_TRIM;
      chan_b_phase_trim <= RST_PHASE_TRIM;
      chan_c_input_setup <= RST_INPUT_SETUP;
    end else if (wr_en) begin
      case (paddr)
        ADDR_ANALOG_GAIN: begin
          chan_b_analog_gain <= merge(chan_b_analog_gain,
                                      MASK_ANALOG_GAIN);
        end
        ADDR_VOLUME: begin
          chan_b_digital_volume <= merge(chan_b_digital_volume,
                                         MASK_VOLUME);
        end
        ADDR_GAIN_TRIM: begin
          chan_b_gain_trim <= merge(chan_b_gain_trim,
                                    MASK_GAIN_TRIM);
        end
        ADDR_PHASE_TRIM: begin
          chan_b_phase_trim <= merge(chan_b_phase_trim,
                                     MASK_PHASE_TRIM);
        end
        ADDR_INPUT_SETUP: begin
          chan_c_input_setup <= merge(chan_c_input_setup,
                                      MASK_INPUT_SETUP);
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Reads and error answer
  // ----------------------------------------------------------------
  always_comb begin
    case (paddr)
      ADDR_ANALOG_GAIN: rd_val = chan_b_analog_gain;
      ADDR_VOLUME: rd_val = chan_b_digital_volume;
      ADDR_GAIN_TRIM: rd_val = chan_b_gain_trim;
      ADDR_PHASE_TRIM: rd_val = chan_b_phase_trim;
      ADDR_INPUT_SETUP: rd_val = chan_c_input_setup;
      default: rd_val = 8'h00;
    endcase
  end

  // Unmapped addresses answer with an error and read zero
  assign pslverr = access && !hit;
  assign prdata = (access && !pwrite) ? {24'h000000, rd_val} : 32'h00000000;

  // ----------------------------------------------------------------
  // Decoded channel-two settings
  // ----------------------------------------------------------------
  logic [5:0] chan_b_gain_code;
  logic [3:0] chan_b_gain_trim_code;
  assign chan_b_gain_code = chan_b_analog_gain[GAIN_LSB +: 6];
  assign chan_b_gain_trim_code = chan_b_gain_trim[TRIM_LSB +: 4];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_b <= '0;
    end else begin
      chan_b.gain_db <= chan_b_gain_code;
      chan_b.gain_reserved <= chan_b_gain_code > GAIN_MAX_CODE;
      chan_b.mute <= chan_b_digital_volume == VOLUME_MUTE_CODE;
      // Signed half-dB steps from unity; mute code reports zero
      chan_b.volume_half_db <= (chan_b_digital_volume == VOLUME_MUTE_CODE)
        ? 10'sh000
        : $signed({2'h0, chan_b_digital_volume})
          - $signed({2'h0, VOLUME_UNITY_CODE});
      chan_b.trim_tenth_db <=
        $signed(chan_b_gain_trim_code - TRIM_ZERO_CODE);
      chan_b.phase_delay_cycles <= chan_b_phase_trim;
      chan_b.phase_delay_on <= chan_b_phase_trim != 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Decoded channel-three input setup
  // ----------------------------------------------------------------
  // The global enhancer or gain-control choice is a plain input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_c <= '0;
    end else begin
      chan_c.line_select <= chan_c_input_setup[LINE_BIT];
      chan_c.source_select <=
        acr_source_e'(chan_c_input_setup[SRC_LSB +: 2]);
      chan_c.dc_coupling <= chan_c_input_setup[DC_BIT];
      chan_c.impedance_select <= chan_c_input_setup[IMP_LSB +: 2];
      chan_c.impedance_reserved <= &chan_c_input_setup[IMP_LSB +: 2];
      chan_c.enhancer_enable <= chan_c_input_setup[ENH_BIT];
      chan_c.dynamic_range_enhancer <= chan_c_input_setup[ENH_BIT]
        && !automatic_gain_control_select;
      chan_c.automatic_gain_control <= chan_c_input_setup[ENH_BIT]
        && automatic_gain_control_select;
    end
  end

  // ----------------------------------------------------------------
  // Assertions: write path
  // ----------------------------------------------------------------
  // Register checks look one edge after the access; decoded outputs
  // lag the registers by one more edge
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_VOL_WRITE: assert property (
    wr_en && paddr == ADDR_VOLUME && pstrb[0]
    |=> chan_b_digital_volume == $past(pwdata[7:0]))
    else $error("volume write did not land");

  AST_TRIM_WRITE: assert property (
    wr_en && paddr == ADDR_GAIN_TRIM && pstrb[0]
    |=> chan_b_gain_trim == {$past(pwdata[7:4]), 4'h0})
    else $error("trim write did not land");

  AST_PHASE_WRITE: assert property (
    wr_en && paddr == ADDR_PHASE_TRIM && pstrb[0]
    |=> chan_b_phase_trim == $past(pwdata[7:0]))
    else $error("phase write did not land");

  AST_SETUP_WRITE: assert property (
    wr_en && paddr == ADDR_INPUT_SETUP && pstrb[0]
    |=> chan_c_input_setup == ($past(pwdata[7:0]) & 8'hfd))
    else $error("setup write did not land");

  // A write without the low strobe, or to a hole, must change nothing
  AST_NO_STRAY_WRITE: assert property (
    access && pwrite && (!pstrb[0] || !hit)
    |=> $stable({chan_b_analog_gain, chan_b_digital_volume,
                 chan_b_gain_trim, chan_b_phase_trim, chan_c_input_setup}))
    else $error("refused write changed a register");

  AST_RSVD_ZERO: assert property (
    chan_b_gain_trim[3:0] == 4'h0 && chan_b_analog_gain[1:0] == 2'h0
    && chan_c_input_setup[1] == 1'b0)
    else $error("reserved bit set");

  AST_RSVD_READ: assert property (
    psel && penable && !pwrite && paddr == ADDR_GAIN_TRIM
    |-> prdata[3:0] == 4'h0 && prdata[31:8] == 24'h000000)
    else $error("reserved trim bits read nonzero");

  // ----------------------------------------------------------------
  // Assertions: channel-two decode
  // ----------------------------------------------------------------
  AST_GAIN_FOLLOWS: assert property (
    wr_en && paddr == ADDR_ANALOG_GAIN && pstrb[0]
    |-> ##2 chan_b.gain_db == $past(pwdata[GAIN_LSB +: 6], 2))
    else $error("gain code not carried to output");

  AST_GAIN_RSVD: assert property (
    chan_b.gain_reserved == $past(chan_b_analog_gain[7:2] > 6'd42))
    else $error("reserved gain flag wrong");

  AST_MUTE_ZERO: assert property (
    chan_b_digital_volume == 8'h00 |=> chan_b.mute)
    else $error("zero volume did not mute");

  AST_MUTE_ONLY_ZERO: assert property (
    chan_b_digital_volume != 8'h00 |=> !chan_b.mute)
    else $error("nonzero volume muted");

  AST_UNITY_VOL: assert property (
    chan_b_digital_volume == 8'hc9 |=> chan_b.volume_half_db == 10'sh000)
    else $error("code 201 is not unity");

  AST_VOL_ENDS: assert property (
    chan_b_digital_volume == 8'h01 || chan_b_digital_volume == 8'hff
    |=> chan_b.volume_half_db
        == ($past(chan_b_digital_volume[7]) ? 10'sd54 : -10'sd200))
    else $error("volume end codes wrong");

  AST_TRIM_ZERO: assert property (
    chan_b_gain_trim[7:4] == 4'h8 |=> chan_b.trim_tenth_db == 4'sh0)
    else $error("trim code 8 not zero dB");

  // 4'sh8 is the most negative trim, minus eight tenths
  AST_TRIM_ENDS: assert property (
    chan_b_gain_trim[7:4] == 4'h0 || chan_b_gain_trim[7:4] == 4'hf
    |=> chan_b.trim_tenth_db == ($past(chan_b_gain_trim[7]) ? 4'sh7 : 4'sh8))
    else $error("trim end codes wrong");

  AST_PHASE_CYCLES: assert property (
    chan_b_phase_trim != 8'h00
    |=> chan_b.phase_delay_on
        && chan_b.phase_delay_cycles == $past(chan_b_phase_trim))
    else $error("phase delay not the code");

  AST_PHASE_OFF: assert property (
    chan_b_phase_trim == 8'h00 |=> !chan_b.phase_delay_on
    && chan_b.phase_delay_cycles == 8'h00)
    else $error("phase zero yields delay");

  // ----------------------------------------------------------------
  // Assertions: channel-three decode
  // ----------------------------------------------------------------
  AST_LINE_BIT: assert property (
    $rose(chan_c_input_setup[7]) |=> chan_c.line_select)
    else $error("line select not applied");

  AST_MIC_BIT: assert property (
    !chan_c_input_setup[LINE_BIT] |=> !chan_c.line_select)
    else $error("microphone input not selected");

  AST_SRC_FOLLOWS: assert property (
    2'(chan_c.source_select) == $past(chan_c_input_setup[6:5]))
    else $error("source select not carried");

  AST_ENH_OFF: assert property (
    !chan_c_input_setup[0]
    |=> !chan_c.dynamic_range_enhancer && !chan_c.automatic_gain_control)
    else $error("enhancer active while disabled");

  AST_ENH_PICK: assert property (
    chan_c_input_setup[0]
    |=> chan_c.dynamic_range_enhancer != chan_c.automatic_gain_control
        && chan_c.automatic_gain_control
           == $past(automatic_gain_control_select))
    else $error("enhancer choice not applied");

  // ----------------------------------------------------------------
  // Cover points
  // ----------------------------------------------------------------
  COV_MUTE: cover property (
    wr_en && paddr == ADDR_VOLUME && pwdata[7:0] == 8'h00);
  COV_ERR: cover property (pslverr);
  COV_PDM: cover property (chan_c.source_select == SRC_DIGITAL_PDM);
  COV_GAIN_CTRL: cover property (chan_c.automatic_gain_control);
  COV_GAIN_RSVD: cover property (chan_b.gain_reserved);

endmodule : acr_regs

//--- tb_acr_regs.sv
// Testbench for the channel configuration register bank
`timescale 1ns/10ps
`define CHK(nm, e, g) begin \
  n_compared++; \
  if ((g) !== (e)) begin \
    fails++; \
    $display("MISMATCH %s exp %0h got %0h", nm, e, g); \
  end \
end

module tb_acr_regs
  import acr_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite;
  logic automatic_gain_control_select;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic pready, pslverr, err;
  acr_chan_b_s chan_b;
  acr_chan_c_s chan_c;
  int fails, n_compared;
  logic [ADDR_W-1:0] addr_tab [5] = '{ADDR_ANALOG_GAIN, ADDR_VOLUME,
    ADDR_GAIN_TRIM, ADDR_PHASE_TRIM, ADDR_INPUT_SETUP};
  logic [7:0] mask_tab [5] = '{8'hfc, 8'hff, 8'hf0, 8'hff, 8'hfd};
  logic [7:0] vcode [4] = '{8'h00, 8'h01, 8'hc9, 8'hff};
  logic signed [9:0] vexp [4] = '{10'sd0, -10'sd200, 10'sd0, 10'sd54};
  logic [3:0] tcode [3] = '{4'h0, 4'h8, 4'hf};
  logic [3:0] texp [3] = '{4'h8, 4'h0, 4'h7};
  logic [7:0] pcode [3] = '{8'h00, 8'h01, 8'hff};

  acr_regs dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .automatic_gain_control_select(automatic_gain_control_select),
    .chan_b(chan_b), .chan_c(chan_c));

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic give_verdict;
    if (fails == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  // Starts on a fresh edge so psel is never assigned twice in one step
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
    input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fails++;
      give_verdict();
    end
  endtask : apb

  // Two more edges after the register lands in apb: the decoded outputs follow on the first
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d}, 4'h1);
    repeat (2) @(posedge pclk);
  endtask : wr

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0, 4'h0);
    `CHK("prdata", {24'h0, e}, rd)
    `CHK("pslverr", 1'b0, err)
  endtask : rd_chk

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = '0;
    automatic_gain_control_select = 1'b0;
    fails = 0;
    n_compared = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(ADDR_VOLUME, 8'hc9);
    rd_chk(ADDR_GAIN_TRIM, 8'h80);
    rd_chk(ADDR_PHASE_TRIM, 8'h00);
    rd_chk(ADDR_INPUT_SETUP, 8'h00);
    `CHK("vol_db", 10'sd0, chan_b.volume_half_db)
    `CHK("trim", 4'h0, chan_b.trim_tenth_db)
    `CHK("ph_on", 1'b0, chan_b.phase_delay_on)
    // Refused accesses must leave the bank untouched
    apb(1'b1, 12'h200, 32'hff, 4'h1);
    `CHK("slverr_w", 1'b1, err)
    apb(1'b0, 12'h200, 32'h0, 4'h0);
    `CHK("slverr_r", 1'b1, err)
    `CHK("rd_unmap", 32'h0, rd)
    apb(1'b1, ADDR_VOLUME, 32'h11, 4'he);
    `CHK("slverr_s", 1'b0, err)
    rd_chk(ADDR_VOLUME, 8'hc9);
    for (int i = 0; i < 5; i++) begin
      wr(addr_tab[i], 8'hff);
      rd_chk(addr_tab[i], mask_tab[i]);
    end
    `CHK("imp_rsv", 1'b1, chan_c.impedance_reserved)
    `CHK("imp", 2'h3, chan_c.impedance_select)
    `CHK("enh", 1'b1, chan_c.enhancer_enable)
    `CHK("range_enh", 1'b1, chan_c.dynamic_range_enhancer)
    `CHK("gain_ctl", 1'b0, chan_c.automatic_gain_control)
    automatic_gain_control_select <= 1'b1;
    repeat (2) @(posedge pclk);
    `CHK("gain_ctl", 1'b1, chan_c.automatic_gain_control)
    `CHK("range_enh", 1'b0, chan_c.dynamic_range_enhancer)
    wr(ADDR_INPUT_SETUP, 8'h00);
    `CHK("gain_ctl_off", 1'b0, chan_c.automatic_gain_control)
    `CHK("line", 1'b0, chan_c.line_select)
    `CHK("dc_off", 1'b0, chan_c.dc_coupling)
    `CHK("imp_off", 2'h0, chan_c.impedance_select)
    `CHK("enh_off", 1'b0, chan_c.enhancer_enable)
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_INPUT_SETUP, {1'b1, 2'(s), 5'h10});
      `CHK("src", acr_source_e'(s), chan_c.source_select)
      `CHK("line", 1'b1, chan_c.line_select)
      `CHK("dc", 1'b1, chan_c.dc_coupling)
    end
    wr(ADDR_ANALOG_GAIN, {6'd42, 2'b11});
    `CHK("gain", 6'd42, chan_b.gain_db)
    `CHK("g_rsv", 1'b0, chan_b.gain_reserved)
    wr(ADDR_ANALOG_GAIN, {6'd43, 2'b00});
    `CHK("g_rsv", 1'b1, chan_b.gain_reserved)
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_VOLUME, vcode[i]);
      `CHK("vol_db", vexp[i], chan_b.volume_half_db)
      `CHK("mute", (i == 0), chan_b.mute)
    end
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_GAIN_TRIM, {tcode[i], 4'h0});
      `CHK("trim", texp[i], chan_b.trim_tenth_db)
      wr(ADDR_PHASE_TRIM, pcode[i]);
      `CHK("ph_cyc", pcode[i], chan_b.phase_delay_cycles)
      `CHK("ph_on", (i != 0), chan_b.phase_delay_on)
    end
    // Reset in mid-run: registers and decoded outputs return to defaults
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(ADDR_ANALOG_GAIN, 8'h00);
    rd_chk(ADDR_VOLUME, 8'hc9);
    rd_chk(ADDR_GAIN_TRIM, 8'h80);
    rd_chk(ADDR_PHASE_TRIM, 8'h00);
    rd_chk(ADDR_INPUT_SETUP, 8'h00);
    `CHK("vol_db_rst", 10'sd0, chan_b.volume_half_db)
    `CHK("trim_rst", 4'h0, chan_b.trim_tenth_db)
    `CHK("ph_on_rst", 1'b0, chan_b.phase_delay_on)
    `CHK("line_rst", 1'b0, chan_c.line_select)
    give_verdict();
  end
endmodule : tb_acr_regs
